//--- common/ebcs_consts.svh
// Purpose: offsets, field positions, reset values and widths of the bus sequencer
// Assumes: included by its bare name from the design and the test
// Notes: byte addresses on a 32-bit register bus
`ifndef EBCS_CONSTS_SVH
`define EBCS_CONSTS_SVH

`define EBCS_OFF_CTRL      8'h00
`define EBCS_OFF_TIMING0   8'h04
`define EBCS_OFF_ADDR      8'h14
`define EBCS_OFF_WDATA     8'h18
`define EBCS_OFF_CMD       8'h1c
`define EBCS_OFF_STATUS    8'h20
`define EBCS_OFF_RDATA     8'h24

`define EBCS_CTRL_MUX      0
`define EBCS_CTRL_RDY_EN   1
`define EBCS_CTRL_RDY_POL  2
`define EBCS_CTRL_RDY_ASY  3
`define EBCS_CTRL_CS_LO    4
`define EBCS_CTRL_W        6

`define EBCS_CMD_WRITE     0
`define EBCS_CMD_UBE       1
`define EBCS_STAT_BUSY     0

`define EBCS_CTRL_RESET    6'h00
`define EBCS_TIMING_RESET  13'h0000
`define EBCS_TIMING_W      13

`define EBCS_RESP_OKAY     2'b00
`define EBCS_RESP_SLVERR   2'b10

`endif

//--- common/ebcs_pkg.sv
// Purpose: types shared by the external bus cycle sequencer
// Assumes: one phase time unit is one link clock cycle
// Notes: timing word packs all five phase lengths of one chip select
package ebcs_pkg;

	// phase lengths of one chip select, 13 bits
	typedef struct packed {
		logic [1:0] hold_len;   // hold phase 0..3
		logic [4:0] acc_m1;     // access phase minus one, 1..32
		logic       wsetup;     // write setup or tristate 0..1
		logic [1:0] cmd_dly;    // command delay 0..3
		logic [1:0] ab_ext;     // extra setup on window change 0..3
		logic       ab_two;     // setup 1 or 2
	} ebcs_timing_s;

	// one request handed to the link domain
	typedef struct packed {
		ebcs_timing_s tim;
		logic [23:0]  addr;
		logic [15:0]  wdata;
		logic         write;
		logic         ube;
		logic [1:0]   cs;
		logic         mux;
		logic         rdy_en;
		logic         rdy_pol;
		logic         rdy_async;
	} ebcs_req_s;

	typedef enum logic [2:0] {
		EBCS_IDLE = 3'b000,
		EBCS_AB   = 3'b001,
		EBCS_C    = 3'b010,
		EBCS_D    = 3'b011,
		EBCS_E    = 3'b100,
		EBCS_W    = 3'b101,
		EBCS_F    = 3'b110
	} ebcs_phase_e;

endpackage

//--- rtl/ebcs_top.sv
// Purpose: external bus cycle sequencer with an AXI4-Lite register port
// Assumes: link_clk is the bus system clock; ready and read data are sampled on it
// Notes: one bus cycle at a time; a command while busy is dropped
//
// The placing of the registers and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
`include "ebcs_consts.svh"

// How it works
// - each bus cycle walks setup, command delay, write setup, access, hold in order.
// - phase lengths come from the timing register of the selected chip select.
// - setup lasts 1 or 2 units, plus 0..3 units when the chip select changes.
// - command delay is 0..3 units; write setup or tristate is 0..1 unit.
// - access lasts 1..32 units and may be stretched by the ready input.
// - hold phase lasts 0..3 units.
// - read data is captured on the edge that raises the read strobe.
// - the dedicated address is held until after read data capture.
// - multiplexed mode puts address, then write data, on the shared lines.
// - demultiplexed mode drives write data on dedicated lines, address separately.
// - the reference clock output mirrors the bus system clock.
// - the ready active level is selected by a control bit.
// - synchronous ready is sampled directly, with no synchroniser.
// - asynchronous ready passes a synchroniser and always adds a wait state.
// - at each sample, inactive ready adds a wait, active ready ends access.
module ebcs_top #(
	parameter int NUM_CS = 4
) (
	// clocks and reset
	input  wire logic                ref_clk,
	input  wire logic                link_clk,
	input  wire logic                rstn,
	// axi4-lite write address, data and response
	input  wire logic [7:0]          s_axi_awaddr,
	input  wire logic                s_axi_awvalid,
	output logic                     s_axi_awready,
	input  wire logic [31:0]         s_axi_wdata,
	input  wire logic [3:0]          s_axi_wstrb,
	input  wire logic                s_axi_wvalid,
	output logic                     s_axi_wready,
	output logic [1:0]               s_axi_bresp,
	output logic                     s_axi_bvalid,
	input  wire logic                s_axi_bready,
	// axi4-lite read
	input  wire logic [7:0]          s_axi_araddr,
	input  wire logic                s_axi_arvalid,
	output logic                     s_axi_arready,
	output logic [31:0]              s_axi_rdata,
	output logic [1:0]               s_axi_rresp,
	output logic                     s_axi_rvalid,
	input  wire logic                s_axi_rready,
	// external bus pins
	output logic                     bus_reference_clock,
	output logic [NUM_CS-1:0]        chip_select_n,
	output logic                     read_strobe_n,
	output logic                     write_strobe_n,
	output logic                     addr_latch_enable,
	output logic                     upper_byte_enable_n,
	output logic [23:0]              dedicated_address_lines,
	output logic [15:0]              shared_addr_data_lines_out,
	output logic                     shared_addr_data_lines_oe,
	input  wire logic [15:0]         shared_addr_data_lines_in,
	output logic [15:0]              dedicated_data_lines_out,
	output logic                     dedicated_data_lines_oe,
	input  wire logic [15:0]         dedicated_data_lines_in,
	input  wire logic                ready_in
);
	import ebcs_pkg::*;

	// reset release, one copy per domain
	logic       rr1_q, rst_n_q, lr1_q, lrst_n_q;
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			rr1_q   <= 1'b0;
			rst_n_q <= 1'b0;
		end else begin
			rr1_q   <= 1'b1;
			rst_n_q <= rr1_q;
		end
	end
	always_ff @(posedge link_clk or negedge rstn) begin
		if (!rstn) begin
			lr1_q    <= 1'b0;
			lrst_n_q <= 1'b0;
		end else begin
			lr1_q    <= 1'b1;
			lrst_n_q <= lr1_q;
		end
	end

	// register port state
	logic [`EBCS_CTRL_W-1:0]   ctrl_q;
	ebcs_timing_s              tim_q [NUM_CS];
	logic [23:0]               addr_q;
	logic [15:0]               wdata_q, rdata_sw_q;
	logic                      busy_q, req_tgl_q, ack_s1_q, ack_s2_q, ack_seen_q;
	ebcs_req_s                 req_q;
	logic [7:0]                aw_addr_q;
	logic [31:0]               w_data_q;
	logic [3:0]                w_strb_q;
	logic                      aw_have_q, w_have_q;
	logic                      done_tgl_q;
	logic [15:0]               rdata_link_q;
	logic                      wr_hit;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// write channel: address and data taken in either order
	wire do_write = aw_have_q && w_have_q && !s_axi_bvalid;
	always_ff @(posedge ref_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			aw_have_q     <= 1'b0;
			w_have_q      <= 1'b0;
			aw_addr_q     <= 8'h00;
			w_data_q      <= 32'h0000_0000;
			w_strb_q      <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `EBCS_RESP_OKAY;
		end else begin
			s_axi_awready <= !aw_have_q && !s_axi_awready && !do_write;
			s_axi_wready  <= !w_have_q && !s_axi_wready && !do_write;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_q <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end
			if (do_write) begin
				aw_have_q    <= 1'b0;
				w_have_q     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_hit ? `EBCS_RESP_OKAY : `EBCS_RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	always_comb begin
		wr_hit = (aw_addr_q[1:0] == 2'b00) && (aw_addr_q <= `EBCS_OFF_RDATA);
	end

	// control, address and write data registers
	always_ff @(posedge ref_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			ctrl_q  <= `EBCS_CTRL_RESET;
			addr_q  <= 24'h00_0000;
			wdata_q <= 16'h0000;
		end else if (do_write) begin
			if (aw_addr_q == `EBCS_OFF_CTRL) begin
				ctrl_q <= 6'(merge({26'h0, ctrl_q}, w_data_q, w_strb_q));
			end
			if (aw_addr_q == `EBCS_OFF_ADDR) begin
				addr_q <= 24'(merge({8'h00, addr_q}, w_data_q, w_strb_q));
			end
			if (aw_addr_q == `EBCS_OFF_WDATA) begin
				wdata_q <= 16'(merge({16'h0000, wdata_q}, w_data_q, w_strb_q));
			end
		end
	end

	// one timing register per chip select
	for (genvar g = 0; g < NUM_CS; g++) begin : g_tim
		localparam logic [7:0] OFF = 8'(`EBCS_OFF_TIMING0 + 4 * g);
		always_ff @(posedge ref_clk or negedge rst_n_q) begin
			if (!rst_n_q) begin
				tim_q[g] <= `EBCS_TIMING_RESET;
			end else if (do_write && aw_addr_q == OFF) begin
				tim_q[g] <= ebcs_timing_s'(13'(merge({19'h0, tim_q[g]}, w_data_q, w_strb_q)));
			end
		end
	end

	// command launch and completion, handshake toward the link domain
	wire launch = do_write && aw_addr_q == `EBCS_OFF_CMD && w_strb_q[0] && !busy_q;
	wire [1:0] sel_cs = ctrl_q[`EBCS_CTRL_CS_LO +: 2];
	always_ff @(posedge ref_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			busy_q     <= 1'b0;
			req_tgl_q  <= 1'b0;
			req_q      <= '0;
			ack_s1_q   <= 1'b0;
			ack_s2_q   <= 1'b0;
			ack_seen_q <= 1'b0;
			rdata_sw_q <= 16'h0000;
		end else begin
			ack_s1_q <= done_tgl_q;
			ack_s2_q <= ack_s1_q;
			if (launch) begin
				busy_q    <= 1'b1;
				req_tgl_q <= !req_tgl_q;
				req_q     <= '{tim: tim_q[sel_cs], addr: addr_q, wdata: wdata_q,
					write: w_data_q[`EBCS_CMD_WRITE], ube: w_data_q[`EBCS_CMD_UBE],
					cs: sel_cs, mux: ctrl_q[`EBCS_CTRL_MUX],
					rdy_en: ctrl_q[`EBCS_CTRL_RDY_EN], rdy_pol: ctrl_q[`EBCS_CTRL_RDY_POL],
					rdy_async: ctrl_q[`EBCS_CTRL_RDY_ASY]};
			end
			if (ack_s2_q != ack_seen_q) begin
				ack_seen_q <= ack_s2_q;
				busy_q     <= 1'b0;
				rdata_sw_q <= rdata_link_q;
			end
		end
	end

	// read channel
	always_ff @(posedge ref_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= `EBCS_RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= `EBCS_RESP_OKAY;
				s_axi_rdata  <= 32'h0000_0000;
				unique case (s_axi_araddr)
					`EBCS_OFF_CTRL:   s_axi_rdata <= {26'h0, ctrl_q};
					`EBCS_OFF_ADDR:   s_axi_rdata <= {8'h00, addr_q};
					`EBCS_OFF_WDATA:  s_axi_rdata <= {16'h0000, wdata_q};
					`EBCS_OFF_CMD:    s_axi_rdata <= 32'h0000_0000;
					`EBCS_OFF_STATUS: s_axi_rdata <= {31'h0, busy_q};
					`EBCS_OFF_RDATA:  s_axi_rdata <= {16'h0000, rdata_sw_q};
					default: begin
						if (s_axi_araddr[1:0] == 2'b00 && s_axi_araddr >= `EBCS_OFF_TIMING0
							&& s_axi_araddr < `EBCS_OFF_ADDR) begin
							s_axi_rdata <= {19'h0, tim_q[s_axi_araddr[3:2] - 2'd1]};
						end else begin
							s_axi_rresp <= `EBCS_RESP_SLVERR;
						end
					end
				endcase
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// link domain: request pick-up
	logic        rq_s1_q, rq_s2_q, rq_seen_q;
	logic [1:0]  last_cs_q;
	logic        last_vld_q;
	ebcs_phase_e ph_q, ph_d;
	logic [4:0]  cnt_q, cnt_d;
	wire         start = rq_s2_q != rq_seen_q;
	always_ff @(posedge link_clk or negedge lrst_n_q) begin
		if (!lrst_n_q) begin
			rq_s1_q   <= 1'b0;
			rq_s2_q   <= 1'b0;
			rq_seen_q <= 1'b0;
		end else begin
			rq_s1_q <= req_tgl_q;
			rq_s2_q <= rq_s1_q;
			if (start && ph_q == EBCS_IDLE) begin
				rq_seen_q <= rq_s2_q;
			end
		end
	end

	// ready input: direct in sync mode, three-stage agree filter in async mode
	logic rdy_f1_q, rdy_f2_q, rdy_f3_q, rdy_filt_q;
	always_ff @(posedge link_clk or negedge lrst_n_q) begin
		if (!lrst_n_q) begin
			rdy_f1_q   <= 1'b0;
			rdy_f2_q   <= 1'b0;
			rdy_f3_q   <= 1'b0;
			rdy_filt_q <= 1'b0;
		end else begin
			rdy_f1_q <= ready_in;
			rdy_f2_q <= rdy_f1_q;
			rdy_f3_q <= rdy_f2_q;
			if (rdy_f2_q == rdy_f3_q) begin
				rdy_filt_q <= rdy_f3_q;
			end
		end
	end
	wire rdy_lvl    = req_q.rdy_async ? rdy_filt_q : ready_in;
	wire rdy_active = rdy_lvl == req_q.rdy_pol;

	// phase sequencer; phases of zero length are skipped
	wire        win_chg = !last_vld_q || last_cs_q != req_q.cs;
	wire [2:0]  ab_len  = 3'(1 + req_q.tim.ab_two) + (win_chg ? {1'b0, req_q.tim.ab_ext} : 3'd0);
	wire        last    = cnt_q == 5'd0;
	logic       end_acc;
	always_comb begin
		ph_d    = ph_q;
		cnt_d   = last ? 5'd0 : cnt_q - 5'd1;
		end_acc = 1'b0;
		unique case (ph_q)
			EBCS_IDLE: begin
				if (start) begin
					ph_d  = EBCS_AB;
					cnt_d = 5'(ab_len - 3'd1);
				end
			end
			EBCS_AB, EBCS_C, EBCS_D: begin
				if (last) begin
					if (ph_q == EBCS_AB && req_q.tim.cmd_dly != 2'd0) begin
						ph_d  = EBCS_C;
						cnt_d = 5'(req_q.tim.cmd_dly - 2'd1);
					end else if (ph_q != EBCS_D && req_q.tim.wsetup) begin
						ph_d  = EBCS_D;
						cnt_d = 5'd0;
					end else begin
						ph_d  = EBCS_E;
						cnt_d = req_q.tim.acc_m1;
					end
				end
			end
			EBCS_E, EBCS_W: begin
				if (ph_q == EBCS_W || last) begin
					if (!req_q.rdy_en || (ph_q == EBCS_W || !req_q.rdy_async) && rdy_active) begin
						end_acc = 1'b1;
					end else begin
						ph_d = EBCS_W;
					end
				end
				if (end_acc) begin
					ph_d  = req_q.tim.hold_len != 2'd0 ? EBCS_F : EBCS_IDLE;
					cnt_d = 5'(req_q.tim.hold_len - 2'd1);
				end
			end
			EBCS_F: begin
				if (last) begin
					ph_d = EBCS_IDLE;
				end
			end
			default: begin
				ph_d = EBCS_IDLE;
			end
		endcase
	end

	wire finish = ph_q != EBCS_IDLE && ph_d == EBCS_IDLE;
	always_ff @(posedge link_clk or negedge lrst_n_q) begin
		if (!lrst_n_q) begin
			ph_q         <= EBCS_IDLE;
			cnt_q        <= 5'd0;
			last_cs_q    <= 2'd0;
			last_vld_q   <= 1'b0;
			done_tgl_q   <= 1'b0;
			rdata_link_q <= 16'h0000;
		end else begin
			ph_q  <= ph_d;
			cnt_q <= cnt_d;
			if (end_acc && !req_q.write) begin
				rdata_link_q <= req_q.mux ? shared_addr_data_lines_in
					: dedicated_data_lines_in;
			end
			if (finish) begin
				done_tgl_q <= !done_tgl_q;
				last_cs_q  <= req_q.cs;
				last_vld_q <= 1'b1;
			end
		end
	end

	// pin registers follow the next phase so each pin but the reference clock leaves a flip-flop
	wire act   = ph_d != EBCS_IDLE;
	wire strb  = ph_d == EBCS_E || ph_d == EBCS_W;
	wire dphase = act && ph_d != EBCS_AB;
	always_ff @(posedge link_clk or negedge lrst_n_q) begin
		if (!lrst_n_q) begin
			chip_select_n              <= '1;
			read_strobe_n              <= 1'b1;
			write_strobe_n             <= 1'b1;
			addr_latch_enable          <= 1'b0;
			upper_byte_enable_n        <= 1'b1;
			dedicated_address_lines    <= 24'h00_0000;
			shared_addr_data_lines_out <= 16'h0000;
			shared_addr_data_lines_oe  <= 1'b0;
			dedicated_data_lines_out   <= 16'h0000;
			dedicated_data_lines_oe    <= 1'b0;
		end else begin
			for (int i = 0; i < NUM_CS; i++) begin
				chip_select_n[i] <= !(act && req_q.cs == 2'(i));
			end
			read_strobe_n       <= !(strb && !req_q.write);
			write_strobe_n      <= !(strb && req_q.write);
			addr_latch_enable   <= ph_d == EBCS_AB && req_q.mux;
			upper_byte_enable_n <= !(act && req_q.ube);
			if (ph_d == EBCS_AB && ph_q == EBCS_IDLE) begin
				dedicated_address_lines <= req_q.addr;
			end
			if (ph_d == EBCS_AB) begin
				shared_addr_data_lines_out <= req_q.addr[15:0];
			end else if (dphase) begin
				shared_addr_data_lines_out <= req_q.wdata;
			end
			shared_addr_data_lines_oe <= req_q.mux && (ph_d == EBCS_AB
				|| dphase && req_q.write);
			dedicated_data_lines_out  <= req_q.wdata;
			dedicated_data_lines_oe   <= !req_q.mux && dphase && req_q.write;
		end
	end

	assign bus_reference_clock = link_clk;
endmodule

//--- verif/ebcs_ext_mem.sv
// Purpose: external 16-bit memory with ready output
// Assumes: clocked by the bus reference clock
// Notes: released data lines show the inverse of the last word
`timescale 1ns/1ps
module ebcs_ext_mem (
	// bus side
	input  wire logic        clk,
	input  wire logic        rd_n,
	input  wire logic        wr_n,
	input  wire logic        ale,
	input  wire logic [23:0] addr,
	input  wire logic [15:0] ad_out,
	input  wire logic [15:0] d_out,
	output logic      [15:0] dat,
	output logic             rdy,
	// test controls
	input  wire logic        mux,
	input  wire logic        pol,
	input  wire logic [5:0]  wait_n
);
	logic [15:0] mem [256];
	logic [15:0] la = '0;
	logic [15:0] last = '0;
	logic [5:0]  cnt = '0;
	logic [7:0]  ix;
	assign ix = mux ? la[7:0] : addr[7:0];
	always @(posedge clk) begin
		if (ale)
			la <= ad_out;
		if (!wr_n)
			mem[ix] <= mux ? ad_out : d_out;
		if (!rd_n)
			last <= mem[ix];
		cnt <= (!rd_n || !wr_n) ? cnt + 6'h1 : 6'h0;
	end
	assign dat = !rd_n ? mem[ix] : ~last;
	assign rdy = (cnt >= wait_n) ? pol : !pol;
endmodule

//--- verif/ebcs_properties.sv
// Purpose: pin properties of the bus cycle sequencer
// Assumes: all bus pins but the reference clock are registered on link_clk
// Notes: bound to the top module from the test top file
`timescale 1ns/1ps
module ebcs_properties #(
	parameter int NUM_CS = 4
) (
	// clock and reset
	input wire logic              link_clk,
	input wire logic              rstn,
	// bus pins
	input wire logic [NUM_CS-1:0] chip_select_n,
	input wire logic              read_strobe_n,
	input wire logic              write_strobe_n,
	input wire logic              addr_latch_enable,
	input wire logic [23:0]       dedicated_address_lines,
	input wire logic              shared_addr_data_lines_oe,
	input wire logic              dedicated_data_lines_oe
);
	logic sel;
	logic cmd;
	logic drv;
	assign sel = !(&chip_select_n);
	assign cmd = !read_strobe_n || !write_strobe_n;
	assign drv = shared_addr_data_lines_oe || dedicated_data_lines_oe;
	default clocking @(posedge link_clk); endclocking
	default disable iff (!rstn);
	a_cs_onehot: assert property ($onehot0(~chip_select_n))
		else $error("two selects active");
	a_strb_excl: assert property (!(!read_strobe_n && !write_strobe_n))
		else $error("both strobes active");
	a_cmd_in_sel: assert property (cmd |-> sel)
		else $error("strobe outside select");
	a_setup_first: assert property ($fell(&chip_select_n) |-> !cmd)
		else $error("strobe without setup");
	a_ale_setup: assert property (
		addr_latch_enable |-> sel && !cmd && shared_addr_data_lines_oe)
		else $error("latch enable outside setup");
	a_addr_held: assert property (
		sel && $past(sel) |-> $stable(dedicated_address_lines))
		else $error("address moved in cycle");
	a_hold_bound: assert property ($fell(cmd) |-> ##[0:3] !sel)
		else $error("hold too long");
	a_wr_drives: assert property (!write_strobe_n |-> drv)
		else $error("write data floating");
	a_rd_floats: assert property (!read_strobe_n |-> !drv)
		else $error("lines driven in read");
	c_read: cover property ($rose(read_strobe_n));
	c_write: cover property ($rose(write_strobe_n));
	c_ale: cover property ($fell(addr_latch_enable));
endmodule

//--- verif/ebcs_top_test.sv
// Purpose: register and bus-cycle test of the bus cycle sequencer
// Assumes: register map and latencies as handed over with the design
// Notes: a link_clk monitor measures the phase lengths of each cycle
`timescale 1ns/1ps
`include "ebcs_consts.svh"
module ebcs_top_test;
	logic        ref_clk = 0;
	logic        link_clk = 0;
	logic        rstn = 0;
	logic [7:0]  s_axi_awaddr = '0;
	logic [7:0]  s_axi_araddr = '0;
	logic [31:0] s_axi_wdata = '0;
	logic [3:0]  s_axi_wstrb = 4'hf;
	logic        s_axi_awvalid = 0;
	logic        s_axi_wvalid = 0;
	logic        s_axi_bready = 0;
	logic        s_axi_arvalid = 0;
	logic        s_axi_rready = 0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic        bus_reference_clock, read_strobe_n, write_strobe_n, addr_latch_enable;
	logic        upper_byte_enable_n, shared_addr_data_lines_oe, dedicated_data_lines_oe;
	logic        ready_in, done, ubs;
	logic [3:0]  chip_select_n, csv;
	logic [23:0] dedicated_address_lines, adr;
	logic [15:0] shared_addr_data_lines_out, shared_addr_data_lines_in, dedicated_data_lines_out;
	logic [15:0] dedicated_data_lines_in, p_dat, alat, wdat;
	logic        rpol = 1;
	logic        pmux = 0;
	logic [5:0]  rwait = '0;
	int          pre, stl, post, n_mismatch, samples_checked;
	// a line driven by the sequencer shows its value, else the memory's
	assign shared_addr_data_lines_in = shared_addr_data_lines_oe ?
		shared_addr_data_lines_out : p_dat;
	assign dedicated_data_lines_in = dedicated_data_lines_oe ? dedicated_data_lines_out : p_dat;
	always #4 ref_clk = ~ref_clk;
	initial begin
		#1.5;
		forever #6 link_clk = ~link_clk;
	end
	ebcs_top ebcs_top_inst (.ref_clk, .link_clk, .rstn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .bus_reference_clock,
		.chip_select_n, .read_strobe_n, .write_strobe_n, .addr_latch_enable,
		.upper_byte_enable_n, .dedicated_address_lines, .shared_addr_data_lines_out,
		.shared_addr_data_lines_oe, .shared_addr_data_lines_in, .dedicated_data_lines_out,
		.dedicated_data_lines_oe, .dedicated_data_lines_in, .ready_in);
	ebcs_ext_mem ebcs_ext_mem_inst (.clk(bus_reference_clock), .rd_n(read_strobe_n),
		.wr_n(write_strobe_n), .ale(addr_latch_enable), .addr(dedicated_address_lines),
		.ad_out(shared_addr_data_lines_out), .d_out(dedicated_data_lines_out), .dat(p_dat),
		.rdy(ready_in), .mux(pmux), .pol(rpol), .wait_n(rwait));
	always @(negedge link_clk) begin
		chk("refclk", 32'h0, 32'(bus_reference_clock));
		if (!(&chip_select_n)) begin
			csv = chip_select_n;
			adr = dedicated_address_lines;
			if (addr_latch_enable)
				alat = shared_addr_data_lines_out;
			if (!upper_byte_enable_n)
				ubs = 1;
			if (!write_strobe_n)
				wdat = shared_addr_data_lines_oe ? shared_addr_data_lines_out : dedicated_data_lines_out;
			if (!read_strobe_n || !write_strobe_n)
				stl++;
			else if (stl == 0)
				pre++;
			else
				post++;
		end else if (pre > 0)
			done = 1;
	end
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic bump(inout int n);
		n++;
		if (n > 200) begin
			n_mismatch++;
			$display("CHECK FAILED wait expected done seen timeout");
			close_out();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		logic aw, w, b;
		logic [1:0] r;
		@(posedge ref_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		n = 0;
		b = 0;
		while (!b) begin
			@(negedge ref_clk);
			aw = s_axi_awvalid & s_axi_awready;
			w = s_axi_wvalid & s_axi_wready;
			b = s_axi_bvalid;
			r = s_axi_bresp;
			@(posedge ref_clk);
			if (aw)
				s_axi_awvalid <= 0;
			if (w)
				s_axi_wvalid <= 0;
			bump(n);
		end
		s_axi_bready <= 0;
		chk("bresp", 32'(er), 32'(r));
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
		int n;
		logic ar, v;
		logic [1:0] r;
		@(posedge ref_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		n = 0;
		v = 0;
		while (!v) begin
			@(negedge ref_clk);
			ar = s_axi_arvalid & s_axi_arready;
			v = s_axi_rvalid;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge ref_clk);
			if (ar)
				s_axi_arvalid <= 0;
			bump(n);
		end
		s_axi_rready <= 0;
		chk("rresp", 32'(er), 32'(r));
	endtask
	// one bus cycle: control, timing, address, data, then command and wait
	task automatic cyc(input logic [5:0] c, input logic [12:0] t, input logic [23:0] a,
		input logic [15:0] wd, input logic [1:0] cm, input int w, ep, lo, hi, eh);
		int n;
		logic [31:0] d;
		rpol = c[`EBCS_CTRL_RDY_POL];
		pmux = c[`EBCS_CTRL_MUX];
		rwait = w[5:0];
		wr(`EBCS_OFF_CTRL, {26'h0, c}, `EBCS_RESP_OKAY);
		wr(`EBCS_OFF_TIMING0 + {4'h0, c[5:4], 2'b00}, {19'h0, t}, `EBCS_RESP_OKAY);
		wr(`EBCS_OFF_ADDR, {8'h0, a}, `EBCS_RESP_OKAY);
		wr(`EBCS_OFF_WDATA, {16'h0, wd}, `EBCS_RESP_OKAY);
		pre = 0;
		stl = 0;
		post = 0;
		done = 0;
		ubs = 0;
		wr(`EBCS_OFF_CMD, {30'h0, cm}, `EBCS_RESP_OKAY);
		n = 0;
		d = 32'h1;
		while (!done || d[0] !== 1'b0) begin
			rd(`EBCS_OFF_STATUS, d, `EBCS_RESP_OKAY);
			bump(n);
		end
		chk("setup", 32'(ep), 32'(pre));
		chk("access", 32'h1, 32'(stl >= lo && stl <= hi));
		chk("hold", 32'(eh), 32'(post));
		chk("select", {28'h0, ~(4'h1 << c[5:4])}, 32'(csv));
		chk("ube", 32'(cm[1]), 32'(ubs));
		if (c[0])
			chk("latched addr", 32'(a[15:0]), 32'(alat));
		else
			chk("addr", 32'(a), 32'(adr));
		if (cm[0])
			chk("wdata", 32'(wd), 32'(wdat));
		else begin
			rd(`EBCS_OFF_RDATA, d, `EBCS_RESP_OKAY);
			chk("rdata", 32'(wd), d);
		end
	endtask
	task automatic close_out();
		if (n_mismatch == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		logic [31:0] d;
		logic [7:0] ro [4];
		ro = '{`EBCS_OFF_CTRL, `EBCS_OFF_TIMING0, `EBCS_OFF_STATUS, `EBCS_OFF_RDATA};
		repeat (5) @(posedge ref_clk);
		rstn <= 1;
		repeat (3) @(posedge ref_clk);
		foreach (ro[i]) begin
			rd(ro[i], d, `EBCS_RESP_OKAY);
			chk("reset value", 32'h0, d);
		end
		rd(8'h30, d, `EBCS_RESP_SLVERR);
		wr(8'h30, 32'h1, `EBCS_RESP_SLVERR);
		wr(8'h08, 32'hffffffff, `EBCS_RESP_OKAY);
		rd(8'h08, d, `EBCS_RESP_OKAY);
		chk("timing width", 32'h1fff, d);
		cyc(6'h00, 13'h0000, 24'h000012, 16'h1234, 2'b11, 0, 1, 1, 1, 0);
		cyc(6'h00, 13'h18fd, 24'h000012, 16'h1234, 2'b00, 0, 6, 4, 4, 3);
		cyc(6'h11, 13'h17ee, 24'h000021, 16'hbeef, 2'b01, 0, 6, 32, 32, 2);
		cyc(6'h17, 13'h0000, 24'h000021, 16'hbeef, 2'b00, 3, 1, 4, 5, 0);
		cyc(6'h0a, 13'h0000, 24'h000012, 16'h1234, 2'b00, 0, 1, 2, 4, 0);
		cyc(6'h30, 13'h0003, 24'habcdef, 16'h5a5a, 2'b01, 0, 3, 1, 1, 0);
		cyc(6'h30, 13'h0000, 24'habcdef, 16'h5a5a, 2'b00, 0, 1, 1, 1, 0);
		close_out();
	end
endmodule
bind ebcs_top ebcs_properties #(.NUM_CS(NUM_CS)) ebcs_properties_inst (.link_clk, .rstn,
	.chip_select_n, .read_strobe_n, .write_strobe_n, .addr_latch_enable,
	.dedicated_address_lines, .shared_addr_data_lines_oe, .dedicated_data_lines_oe);
